// >>> hdl/pattern_tester_pkg.sv
/*
  Constants shared by the rate-limited pattern tester: register map,
  field positions, reset values, pattern codes and rate-limiter figures.
  Assumes a single 100 MHz clock domain and an APB register master.
*/
// Summary of operation
// - write transfer pushes 128-bit pattern words into the outbound FIFO.
// - read transfer with verify on compares each popped word with regenerated expected word.
// - transfers allowed only a programmed share of each 100-cycle interval.
// - window high for quota cycles; quota 100 gives full throughput.
// - interval counter runs only while a write or read is active.
// - push held low in the cycle after FIFO nearly full or rate window low.
// - pop high only when FIFO not empty and window high.
// - transfer ends when word count equals 32 times total; strobes then drop.
// - end count derived from total length, compared with word counter.
// - parameters carry direction and verify enable; compares data only when enabled.
// - five patterns: zeros, ones, incrementing, decrementing, LFSR.
// - zeros pattern drives all bits low, ones pattern all bits high.
// - counting and LFSR patterns split each 512-byte block into header and data.
// - dword 0 index low, dword 1 zero-padded index high, rest pattern.
// - a mismatching compared read word sets the failure flag.
// - counter resets to 100, counts 1..100; window opens at count 100.
// - LFSR x^31+x^21+x+1, four look-ahead values per clock.
package pattern_tester_pkg;

  // ==========================================================
  // register byte offsets
  localparam logic [7:0] OFS_CTRL        = 8'h00;
  localparam logic [7:0] OFS_STATUS      = 8'h04;
  localparam logic [7:0] OFS_TOTAL_LEN   = 8'h08;
  localparam logic [7:0] OFS_ADDR_LO     = 8'h0C;
  localparam logic [7:0] OFS_ADDR_HI     = 8'h10;
  localparam logic [7:0] OFS_PATTERN     = 8'h14;
  localparam logic [7:0] OFS_RATE        = 8'h18;
  localparam logic [7:0] OFS_WORD_COUNT  = 8'h1C;

  // ==========================================================
  // field positions
  localparam int CTRL_START_BIT  = 0;
  localparam int CTRL_DIR_BIT    = 1;
  localparam int CTRL_VERIFY_BIT = 2;
  localparam int STAT_WR_BIT     = 0;
  localparam int STAT_RD_BIT     = 1;
  localparam int STAT_FAIL_BIT   = 2;

  // ==========================================================
  // rate limiter and block geometry
  localparam logic [6:0]  INTERVAL_LEN   = 7'h64;
  localparam logic [6:0]  RATE_RESET     = 7'h64;
  localparam int          BLOCK_WORDS_LG = 5;
  localparam logic [30:0] LFSR_SEED      = 31'h0000_0001;

  // ==========================================================
  // pattern choice codes
  typedef enum logic [2:0] {
    PAT_ZEROS = 3'h0,
    PAT_ONES  = 3'h1,
    PAT_INC   = 3'h2,
    PAT_DEC   = 3'h3,
    PAT_LFSR  = 3'h4
  } pattern_t;

  // ==========================================================
  // transfer states
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_WRITE,
    ST_READ
  } xfer_state_t;

endpackage

// >>> hdl/pattern_tester.sv
/*
  Rate-limited 128-bit pattern generator and checker beside one user
  port of a storage controller. An APB slave holds the test setup.
  Assumes both FIFOs run on ref_clk; the inbound FIFO is show-ahead,
  so in_fifo_data is valid whenever in_fifo_empty is low.
*/
// The APB register port and the address map were chosen for this implementation.
module pattern_tester (
  input  wire logic         ref_clk,              // 100 MHz clock
  input  wire logic         resetn,               // async reset, low
  input  wire logic         psel,                 // apb select
  input  wire logic         penable,              // apb enable
  input  wire logic         pwrite,               // apb direction
  input  wire logic [7:0]   paddr,                // apb byte address
  input  wire logic [31:0]  pwdata,               // apb write data
  output logic      [31:0]  prdata,               // apb read data
  output logic              pready,               // apb ready
  output logic              pslverr,              // apb error
  output logic              out_fifo_push,        // outbound push
  output logic      [127:0] out_fifo_data,        // outbound word
  input  wire logic         out_fifo_nearly_full, // outbound flag
  output logic              in_fifo_pop,          // inbound pop
  input  wire logic [127:0] in_fifo_data,         // inbound word
  input  wire logic         in_fifo_empty         // inbound flag
);

  // ==========================================================
  // declarations
  pattern_tester_pkg::xfer_state_t state_ff;
  pattern_tester_pkg::xfer_state_t nxt_state;
  logic [31:0]  total_length_ff;
  logic [47:0]  start_block_address_ff;
  logic [2:0]   pattern_choice_ff;
  logic [6:0]   rate_quota_ff;
  logic         dir_read_ff;
  logic         verify_on_ff;
  logic         start_ff;
  logic         fail_ff;
  logic [6:0]   interval_counter_ff;
  logic         rate_window_on_ff;
  logic [36:0]  end_count_ff;
  logic [36:0]  word_counter_ff;
  logic [47:0]  block_index_ff;
  logic [4:0]   word_in_block_ff;
  logic [31:0]  inc_count_ff;
  logic [30:0]  lfsr_ff;
  logic         push_ff;
  logic [127:0] data_ff;
  logic [31:0]  prdata_ff;

  // ==========================================================
  // apb decode
  wire          bus_access = psel & penable;
  wire          bus_wr     = bus_access & pwrite;
  wire          bus_setup  = psel & ~penable;
  wire          hit_ctrl   = paddr == pattern_tester_pkg::OFS_CTRL;
  wire          hit_status = paddr == pattern_tester_pkg::OFS_STATUS;
  wire          hit_len    = paddr == pattern_tester_pkg::OFS_TOTAL_LEN;
  wire          hit_alo    = paddr == pattern_tester_pkg::OFS_ADDR_LO;
  wire          hit_ahi    = paddr == pattern_tester_pkg::OFS_ADDR_HI;
  wire          hit_pat    = paddr == pattern_tester_pkg::OFS_PATTERN;
  wire          hit_rate   = paddr == pattern_tester_pkg::OFS_RATE;
  wire          hit_count  = paddr == pattern_tester_pkg::OFS_WORD_COUNT;
  wire          hit_any    = hit_ctrl | hit_status | hit_len | hit_alo
                           | hit_ahi | hit_pat | hit_rate | hit_count;
  wire          idle       = state_ff == pattern_tester_pkg::ST_IDLE;
  wire          write_active = state_ff == pattern_tester_pkg::ST_WRITE;
  wire          read_active  = state_ff == pattern_tester_pkg::ST_READ;

  // zero wait states; unmapped addresses answer with an error
  assign pready  = 1'b1;
  assign pslverr = bus_access & ~hit_any;
  assign prdata  = prdata_ff;

  // read mux, sampled in the setup phase
  wire [31:0] rd_mux =
      hit_ctrl   ? {29'h0, verify_on_ff, dir_read_ff, 1'b0} :
      hit_status ? {29'h0, fail_ff, read_active, write_active} :
      hit_len    ? total_length_ff :
      hit_alo    ? start_block_address_ff[31:0] :
      hit_ahi    ? {16'h0000, start_block_address_ff[47:32]} :
      hit_pat    ? {29'h0, pattern_choice_ff} :
      hit_rate   ? {25'h0, rate_quota_ff} :
      hit_count  ? word_counter_ff[31:0] : 32'h0000_0000;

  // ==========================================================
  // setup registers; written only while idle so a running test
  // cannot have its parameters pulled from under it
  // parameters from software
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      total_length_ff        <= 32'h0000_0000;
      start_block_address_ff <= 48'h0000_0000_0000;
      pattern_choice_ff      <= 3'h0;
      rate_quota_ff          <= pattern_tester_pkg::RATE_RESET;
      dir_read_ff            <= 1'b0;
      verify_on_ff           <= 1'b0;
    end else if (bus_wr && idle) begin
      if (hit_len) total_length_ff <= pwdata;
      if (hit_alo) start_block_address_ff[31:0] <= pwdata;
      if (hit_ahi) start_block_address_ff[47:32] <= pwdata[15:0];
      if (hit_pat) pattern_choice_ff <= pwdata[2:0];
      if (hit_rate) rate_quota_ff <= pwdata[6:0];
      if (hit_ctrl) begin
        dir_read_ff  <= pwdata[pattern_tester_pkg::CTRL_DIR_BIT];
        verify_on_ff <= pwdata[pattern_tester_pkg::CTRL_VERIFY_BIT];
      end
    end
  end

  // start strobe and read data capture
  // one-cycle start pulse
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      start_ff  <= 1'b0;
      prdata_ff <= 32'h0000_0000;
    end else begin
      start_ff <= bus_wr & idle & hit_ctrl
                & pwdata[pattern_tester_pkg::CTRL_START_BIT];
      if (bus_setup && !pwrite) prdata_ff <= rd_mux;
    end
  end

  // ==========================================================
  // transfer state
  // end detection
  wire at_end = word_counter_ff == end_count_ff;
  wire write_start_pulse = start_ff & ~dir_read_ff;
  wire read_start_pulse  = start_ff & dir_read_ff;

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      pattern_tester_pkg::ST_IDLE: begin
        if (write_start_pulse) nxt_state = pattern_tester_pkg::ST_WRITE;
        if (read_start_pulse) nxt_state = pattern_tester_pkg::ST_READ;
      end
      pattern_tester_pkg::ST_WRITE: begin
        if (at_end) nxt_state = pattern_tester_pkg::ST_IDLE;
      end
      pattern_tester_pkg::ST_READ: begin
        if (at_end) nxt_state = pattern_tester_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) state_ff <= pattern_tester_pkg::ST_IDLE;
    else state_ff <= nxt_state;
  end

  // ==========================================================
  // rate limiter
  // counter only while active
  // count 1..100, window opens at 100
  wire       active    = write_active | read_active;
  wire       cnt_top   = interval_counter_ff == pattern_tester_pkg::INTERVAL_LEN;
  wire [6:0] cnt_inc   = interval_counter_ff + 7'h01;
  wire [6:0] nxt_count = !active ? pattern_tester_pkg::RATE_RESET :
                         cnt_top ? 7'h01 : cnt_inc;

  wire win_open  = active & cnt_top & (rate_quota_ff != 7'h00);
  wire win_close = interval_counter_ff == rate_quota_ff;
  wire nxt_window = !active  ? 1'b0 :
                    win_open ? 1'b1 :
                    win_close ? 1'b0 : rate_window_on_ff;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      interval_counter_ff <= pattern_tester_pkg::RATE_RESET;
      rate_window_on_ff   <= 1'b0;
    end else begin
      interval_counter_ff <= nxt_count;
      rate_window_on_ff   <= nxt_window;
    end
  end

  // ==========================================================
  // flow control
  // push gated by full and window
  wire push_go = write_active & rate_window_on_ff
               & ~out_fifo_nearly_full & ~at_end;
  // pop gated by empty and window
  assign in_fifo_pop = read_active & rate_window_on_ff
                     & ~in_fifo_empty & ~at_end;
  wire advance = push_go | in_fifo_pop;

  // ==========================================================
  // pattern generator
  // lfsr x^31+x^21+x+1
  function automatic logic [30:0] lfsr_step(input logic [30:0] s);
    lfsr_step = {s[29:0], s[30] ^ s[20] ^ s[0]};
  endfunction

  logic [30:0] lfsr_la [0:4];
  logic [31:0] dword   [0:3];
  wire         header_word = word_in_block_ff == 5'h00;
  wire         framed = pattern_choice_ff == pattern_tester_pkg::PAT_INC
                      | pattern_choice_ff == pattern_tester_pkg::PAT_DEC
                      | pattern_choice_ff == pattern_tester_pkg::PAT_LFSR;

  assign lfsr_la[0] = lfsr_ff;

  genvar k;
  generate
    for (k = 0; k < 4; k = k + 1) begin : g_dw
      assign lfsr_la[k+1] = lfsr_step(lfsr_la[k]);
      wire [31:0] inc_val = inc_count_ff + 32'(k);
      wire [31:0] pat_val =
        pattern_choice_ff == pattern_tester_pkg::PAT_ONES ? 32'hFFFF_FFFF :
        pattern_choice_ff == pattern_tester_pkg::PAT_INC  ? inc_val :
        pattern_choice_ff == pattern_tester_pkg::PAT_DEC  ? ~inc_val :
        pattern_choice_ff == pattern_tester_pkg::PAT_LFSR ? {1'b0, lfsr_la[k]} :
        32'h0000_0000;
      if (k == 0) begin : g_h0
        assign dword[k] = (framed && header_word) ? block_index_ff[31:0] : pat_val;
      end else if (k == 1) begin : g_h1
        assign dword[k] = (framed && header_word) ?
                          {16'h0000, block_index_ff[47:32]} : pat_val;
      end else begin : g_pd
        assign dword[k] = pat_val;
      end
    end
  endgenerate

  wire [127:0] pattern_word = {dword[3], dword[2], dword[1], dword[0]};

  // ==========================================================
  // generator state, advanced once per transferred word
  // block index per block
  wire last_in_block = word_in_block_ff == 5'h1F;
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      block_index_ff   <= 48'h0000_0000_0000;
      word_in_block_ff <= 5'h00;
      inc_count_ff     <= 32'h0000_0000;
      lfsr_ff          <= pattern_tester_pkg::LFSR_SEED;
      word_counter_ff  <= 37'h0;
      end_count_ff     <= 37'h0;
    end else if (start_ff && idle) begin
      block_index_ff   <= start_block_address_ff;
      word_in_block_ff <= 5'h00;
      inc_count_ff     <= 32'h0000_0000;
      lfsr_ff          <= pattern_tester_pkg::LFSR_SEED;
      word_counter_ff  <= 37'h0;
      end_count_ff     <= {total_length_ff, 5'h00};
    end else if (advance) begin
      if (last_in_block) block_index_ff <= block_index_ff + 48'h1;
      word_in_block_ff <= word_in_block_ff + 5'h01;
      inc_count_ff     <= inc_count_ff + 32'h0000_0004;
      lfsr_ff          <= lfsr_la[4];
      word_counter_ff  <= word_counter_ff + 37'h1;
    end
  end

  // ==========================================================
  // outbound strobe and data, both from flip-flops
  // push pattern words
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      push_ff <= 1'b0;
      data_ff <= 128'h0;
    end else begin
      push_ff <= push_go;
      if (push_go) data_ff <= pattern_word;
    end
  end

  assign out_fifo_push = push_ff;
  assign out_fifo_data = data_ff;

  // ==========================================================
  // checker; fail is cleared by a read start, which cannot meet
  // a compare because starts are taken only while idle
  // compare popped word
  wire mismatch = in_fifo_pop & verify_on_ff & (in_fifo_data != pattern_word);
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) fail_ff <= 1'b0;
    else if (mismatch) fail_ff <= 1'b1;
    else if (read_start_pulse && idle) fail_ff <= 1'b0;
  end

endmodule

// >>> testbench/pattern_tester_checker.sv
/*
  Port checker for pattern_tester.
  Assumes the rate and pattern registers are written only while idle.
*/
module pattern_tester_checker (
  input wire logic         ref_clk,              // clock
  input wire logic         resetn,               // reset, low
  input wire logic         psel,                 // apb select
  input wire logic         penable,              // apb enable
  input wire logic         pwrite,               // apb write
  input wire logic [7:0]   paddr,                // apb address
  input wire logic [31:0]  pwdata,               // apb wdata
  input wire logic [31:0]  prdata,               // apb rdata
  input wire logic         pready,               // apb ready
  input wire logic         pslverr,              // apb error
  input wire logic         out_fifo_push,        // push
  input wire logic [127:0] out_fifo_data,        // push word
  input wire logic         out_fifo_nearly_full, // stop
  input wire logic         in_fifo_pop,          // pop
  input wire logic         in_fifo_empty         // empty
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] quota_ff;
  logic [2:0] pat_ff;
  logic [7:0] run_ff;
  wire        acc = psel & penable;
  wire        bad = paddr > 8'h1C;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  // ==========================================================
  // shadow of quota and pattern, length of transfer runs
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      quota_ff <= 8'h64;
      pat_ff   <= 3'h0;
      run_ff   <= 8'h00;
    end else begin
      if (acc && pwrite && paddr == pattern_tester_pkg::OFS_RATE) quota_ff <= pwdata[7:0];
      if (acc && pwrite && paddr == pattern_tester_pkg::OFS_PATTERN) pat_ff <= pwdata[2:0];
      run_ff <= (out_fifo_push || in_fifo_pop) ? run_ff + 8'h01 : 8'h00;
    end
  end
  sequence full_seen;
    out_fifo_nearly_full;
  endsequence
  // ==========================================================
  // assertions
  chk_ready_high: assert property (acc |-> pready)
    else $error("pready low in access");
  chk_err_access: assert property (pslverr |-> acc)
    else $error("pslverr outside access");
  chk_err_unmapped: assert property (acc && bad |-> pslverr)
    else $error("unmapped access not refused");
  chk_rdata_unmapped: assert property (acc && bad && !pwrite |-> prdata == 32'h0)
    else $error("unmapped read data not zero");
  chk_full_stops: assert property (full_seen |=> !out_fifo_push)
    else $error("push after nearly full");
  chk_pop_data: assert property (in_fifo_pop |-> !in_fifo_empty)
    else $error("pop while empty");
  chk_one_direction: assert property (!(out_fifo_push && in_fifo_pop))
    else $error("push and pop together");
  chk_run_quota: assert property (out_fifo_push || in_fifo_pop |-> run_ff < quota_ff || quota_ff >= 8'h64)
    else $error("transfer run exceeds quota");
  chk_zeros_data: assert property (out_fifo_push && pat_ff == 3'h0 |-> out_fifo_data == 128'h0)
    else $error("zeros pattern word not zero");
  chk_ones_data: assert property (out_fifo_push && pat_ff == 3'h1 |-> out_fifo_data == ~128'h0)
    else $error("ones pattern word not ones");
endmodule
bind pattern_tester pattern_tester_checker chk_u (.ref_clk(ref_clk), .resetn(resetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .out_fifo_push(out_fifo_push), .out_fifo_data(out_fifo_data),
  .out_fifo_nearly_full(out_fifo_nearly_full), .in_fifo_pop(in_fifo_pop), .in_fifo_empty(in_fifo_empty));

// >>> testbench/fifo_partner.sv
/*
  Model of the two FIFOs at the controller port: stores pushed words,
  replays them on pops. Same clock as the tester.
*/
module fifo_partner (
  input  wire logic         ref_clk,              // clock
  input  wire logic         resetn,               // reset, low
  input  wire logic         out_fifo_push,        // push
  input  wire logic [127:0] out_fifo_data,        // push word
  output logic              out_fifo_nearly_full, // stop
  input  wire logic         in_fifo_pop,          // pop
  output logic      [127:0] in_fifo_data,         // show-ahead word
  output logic              in_fifo_empty,        // empty
  input  wire logic         stall,                // stall 8 of 16
  input  wire logic         corrupt,              // flip bit 0
  input  wire logic         rewind,               // replay from 0
  input  wire logic         clear                 // drop all
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [127:0] mem [0:255];
  logic [7:0]   wcnt;
  logic [7:0]   rcnt;
  logic [7:0]   cyc;
  wire          hold = stall & cyc[3];
  // ==========================================================
  // flags; an empty queue shows the inverse so stale data never matches
  assign out_fifo_nearly_full = hold;
  assign in_fifo_empty        = hold | (rcnt == wcnt);
  assign in_fifo_data         = in_fifo_empty ? ~mem[rcnt] : mem[rcnt] ^ {127'h0, corrupt};
  // ==========================================================
  // storage and pointers
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      wcnt <= 8'h00;
      rcnt <= 8'h00;
      cyc  <= 8'h00;
    end else begin
      cyc <= cyc + 8'h01;
      if (out_fifo_push) begin
        mem[wcnt] <= out_fifo_data;
        wcnt      <= wcnt + 8'h01;
      end
      if (in_fifo_pop) rcnt <= rcnt + 8'h01;
      if (rewind || clear) rcnt <= 8'h00;
      if (clear) wcnt <= 8'h00;
    end
  end
endmodule

// >>> testbench/testbench.sv
/*
  Testbench for pattern_tester: APB setup, write and read transfers
  against the FIFO model. Needs the checker and the FIFO model.
*/
`define CHK(n, e, s) begin num_checks++; if ((s) !== (e)) begin err_count++; \
  $display("ERROR %s exp %0h got %0h", n, e, s); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd, e;
  logic pready, pslverr, er, out_fifo_push, out_fifo_nearly_full, in_fifo_pop, in_fifo_empty;
  logic [127:0] out_fifo_data, in_fifo_data;
  logic stall = 0, corrupt = 0, rewind = 0, clear = 0;
  logic [47:0] a0 = 48'h0012_FFFF_FFFF;
  int err_count = 0, num_checks = 0, run = 0, max_run = 0;
  always #5 ref_clk = ~ref_clk;
  pattern_tester dut_u (.ref_clk(ref_clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .out_fifo_push(out_fifo_push), .out_fifo_data(out_fifo_data), .out_fifo_nearly_full(out_fifo_nearly_full),
    .in_fifo_pop(in_fifo_pop), .in_fifo_data(in_fifo_data), .in_fifo_empty(in_fifo_empty));
  fifo_partner far_u (.ref_clk(ref_clk), .resetn(resetn), .out_fifo_push(out_fifo_push),
    .out_fifo_data(out_fifo_data), .out_fifo_nearly_full(out_fifo_nearly_full), .in_fifo_pop(in_fifo_pop),
    .in_fifo_data(in_fifo_data), .in_fifo_empty(in_fifo_empty), .stall(stall), .corrupt(corrupt),
    .rewind(rewind), .clear(clear));
  // longest unbroken run of transfers
  always @(posedge ref_clk) begin
    run = (out_fifo_push || in_fifo_pop) ? run + 1 : 0;
    if (run > max_run) max_run = run;
  end
  // one apb transfer, held until pready is seen
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // one-cycle strobe to the fifo model: 1 replays from word 0, 0 empties it
  task pulse(input logic rw);
    @(posedge ref_clk);
    if (rw) rewind <= 1'b1;
    else clear <= 1'b1;
    @(posedge ref_clk);
    rewind <= 1'b0;
    clear <= 1'b0;
  endtask
  task xfer(input int p, input int q, input int n, input logic [2:0] c);
    apb(1'b1, pattern_tester_pkg::OFS_TOTAL_LEN, 32'(n));
    apb(1'b1, pattern_tester_pkg::OFS_ADDR_LO, a0[31:0]);
    apb(1'b1, pattern_tester_pkg::OFS_ADDR_HI, {16'h0, a0[47:32]});
    apb(1'b1, pattern_tester_pkg::OFS_PATTERN, 32'(p));
    apb(1'b1, pattern_tester_pkg::OFS_RATE, 32'(q));
    apb(1'b1, pattern_tester_pkg::OFS_CTRL, {29'h0, c});
    repeat (4) @(posedge ref_clk);
    do apb(1'b0, pattern_tester_pkg::OFS_STATUS, 32'h0); while (rd[1:0] !== 2'b00);
    repeat (2) @(posedge ref_clk);
  endtask
  // expected dword g of a run
  function automatic logic [31:0] exp_dw(input int p, input int g);
    logic [47:0] idx;
    idx = a0 + 48'(g / 128);
    if (p == 0) return 32'h0;
    if (p == 1) return 32'hFFFF_FFFF;
    if (g % 128 == 0) return idx[31:0];
    if (g % 128 == 1) return {16'h0, idx[47:32]};
    return (p == 2) ? 32'(g) : ~32'(g);
  endfunction
  task stop_test;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial begin
    #300000;
    err_count++;
    stop_test();
  end
  initial begin
    repeat (8) @(posedge ref_clk);
    resetn <= 1'b1;
    apb(1'b0, pattern_tester_pkg::OFS_RATE, 32'h0);
    `CHK("rate reset", 32'h64, rd)
    apb(1'b0, 8'h40, 32'h0);
    `CHK("unmapped err", 1'b1, er)
    $display("register test done");
    for (int p = 0; p < 5; p++) begin
      pulse(1'b0);
      stall <= 1'b1;
      xfer(p, 100, 2, 3'b001);
      `CHK("words pushed", 8'h40, far_u.wcnt)
      for (int g = 0; g < 256; g++) begin
        e = exp_dw(p, g);
        // lfsr data dwords follow from the dword before; the first is the seed stepped twice
        if (p == 4 && g % 128 > 2) begin
          rd = far_u.mem[(g - 1) / 4][32 * ((g - 1) % 4) +: 32];
          e = {1'b0, rd[29:0], rd[30] ^ rd[20] ^ rd[0]};
        end
        if (p == 4 && g == 2) e = 32'h0000_0007;
        if (!(p == 4 && g == 130)) `CHK("pattern dword", e, far_u.mem[g / 4][32 * (g % 4) +: 32])
      end
      pulse(1'b1);
      xfer(p, 100, 2, 3'b111);
      apb(1'b0, pattern_tester_pkg::OFS_STATUS, 32'h0);
      `CHK("clean read", 1'b0, rd[2])
      apb(1'b0, pattern_tester_pkg::OFS_WORD_COUNT, 32'h0);
      `CHK("word count", 32'h40, rd)
      $display("pattern %0d test done", p);
    end
    pulse(1'b0);
    stall <= 1'b0;
    max_run = 0;
    xfer(2, 40, 4, 3'b001);
    `CHK("rate run", 40, max_run)
    $display("rate test done");
    stall <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      pulse(1'b1);
      corrupt <= (i < 2);
      xfer(2, 100, 4, {i > 0, 2'b11});
      apb(1'b0, pattern_tester_pkg::OFS_STATUS, 32'h0);
      `CHK("fail flag", i == 1, rd[2])
    end
    $display("compare test done");
    stop_test();
  end
endmodule
